// ==== bench/standby_halt_controller_test.sv ====
`timescale 1ns/1ps
module standby_halt_controller_test;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic halt_exec = 1'b0;
    logic [1:0] sel = 2'h0;
    logic keep_wr = 1'b0;
    logic keep_val = 1'b0;
    logic warm_wr = 1'b0;
    logic warm_val = 1'b0;
    logic [2:0] mask = 3'h0;
    logic mreq = 1'b0;
    logic [2:0] mlvl = 3'h0;
    logic [2:0] i0lvl = 3'h0;
    logic req_nmi = 1'b0;
    logic req_ext_irq_zero = 1'b0;
    logic req_drop = 1'b0;
    logic nmi_pin, ext_irq_zero, cpu_halted, dummy_cycle, sys_clk_gate_en, periph_run, osc_enable;
    logic osc_out, pins_float, pins_hold, gated_inputs_en, wake_release, wake_service, irq0_flag_keep;
    logic stop_pin_drive_keep, warm_sel, doubler_ready;
    logic [2:0] service_level;
    logic [2:0] hi, lo;
    logic [7:0] seen;
    logic [15:0] lfsr = 16'h969b;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cnt, gate_hi, warm;

    standby_halt_controller #(.WARM_SHORT(16), .WARM_LONG(32)) standby_halt_controller_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .halt_exec(halt_exec),
        .halt_mode_select(sel), .stop_pin_drive_keep_wr(keep_wr), .stop_pin_drive_keep_val(keep_val),
        .warm_sel_wr(warm_wr), .warm_sel_val(warm_val), .interrupt_mask_level(mask),
        .maskable_req(mreq), .maskable_level(mlvl), .nmi_pin(nmi_pin), .ext_irq_zero(ext_irq_zero),
        .ext_irq_zero_level(i0lvl), .cpu_halted(cpu_halted), .dummy_cycle(dummy_cycle),
        .sys_clk_gate_en(sys_clk_gate_en), .periph_run(periph_run), .osc_enable(osc_enable),
        .osc_out(osc_out), .pins_float(pins_float), .pins_hold(pins_hold),
        .gated_inputs_en(gated_inputs_en), .wake_release(wake_release), .wake_service(wake_service),
        .service_level(service_level), .irq0_flag_keep(irq0_flag_keep),
        .stop_pin_drive_keep(stop_pin_drive_keep), .warm_sel(warm_sel), .doubler_ready(doubler_ready));

    wake_requester wake_requester_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .req_nmi(req_nmi), .req_ext_irq_zero(req_ext_irq_zero), .req_drop(req_drop),
        .wake_release(wake_release), .nmi_pin(nmi_pin), .ext_irq_zero(ext_irq_zero));

    always #25 sys_clk = ~sys_clk;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // Returns {release, service, level} for one set of pending requests.
    function automatic logic [4:0] model(input logic [1:0] mode, input logic [2:0] msk, input logic mr,
        input logic [2:0] ml, input logic nmi, input logic i0, input logic [2:0] il);
        logic [2:0] best;
        logic svc;
        best = 3'h0;
        svc = 1'b0;
        if (nmi) return {2'b11, standby_pkg::NMI_LEVEL};
        if (mr && mode == standby_pkg::HALT_SEL_RUN && ml > msk)
        begin
            best = ml;
            svc = 1'b1;
        end
        if (i0 && il > msk && il > best)
        begin
            best = il;
            svc = 1'b1;
        end
        if (i0 || svc) return {1'b1, svc, best};
        return 5'h0;
    endfunction : model

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask : step

    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : final_report

    task automatic halt(input logic [1:0] mode);
        halt_exec = 1'b1;
        sel = mode;
        step(1);
        halt_exec = 1'b0;
    endtask : halt

    task automatic no_wake(input int n);
        seen = 8'h0;
        repeat (n)
        begin
            step(1);
            seen = seen + {7'h0, wake_release};
        end
    endtask : no_wake

    task automatic wait_wake(input int lim);
        cnt = 0;
        gate_hi = 0;
        while (wake_release !== 1'b1 && cnt < lim)
        begin
            gate_hi += (sys_clk_gate_en === 1'b1);
            step(1);
            cnt++;
        end
    endtask : wait_wake

    task automatic verdict(input logic [4:0] e);
        check({6'h0, wake_release, wake_service}, {6'h0, e[4:3]});
        if (e[3])
            check({5'h0, service_level}, {5'h0, e[2:0]});
        else
            check({7'h0, irq0_flag_keep}, 8'h1);
    endtask : verdict

    initial
    begin
        step(10);
        reset_n = 1'b1;
        check({cpu_halted, sys_clk_gate_en, periph_run, osc_enable, osc_out, pins_float, pins_hold,
            gated_inputs_en}, 8'h71);
        check({5'h0, stop_pin_drive_keep, warm_sel, doubler_ready}, 8'h0);
        repeat (3)
        begin
            lfsr = lfsr_next(lfsr);
            mask = 3'h1 + {1'b0, lfsr[1:0]};
            hi = mask + 3'h1 + {2'h0, lfsr[2]};
            lo = mask - 3'h1;
            halt(standby_pkg::HALT_SEL_RUN);
            check({4'h0, cpu_halted, dummy_cycle, sys_clk_gate_en, periph_run}, 8'h0f);
            mreq = 1'b1;
            mlvl = lo;
            no_wake(8);
            check(seen, 8'h0);
            mlvl = hi;
            wait_wake(4);
            verdict(model(standby_pkg::HALT_SEL_RUN, mask, 1'b1, hi, 1'b0, 1'b0, 3'h0));
            mreq = 1'b0;
            step(2);
            halt(standby_pkg::HALT_SEL_IDLE);
            step(4);
            check({4'h0, cpu_halted, sys_clk_gate_en, periph_run, osc_enable}, 8'h09);
            mreq = 1'b1;
            no_wake(8);
            check(seen, 8'h0);
            mreq = 1'b0;
            i0lvl = lo;
            req_ext_irq_zero = 1'b1;
            step(1);
            req_ext_irq_zero = 1'b0;
            wait_wake(10);
            verdict(model(standby_pkg::HALT_SEL_IDLE, mask, 1'b0, 3'h0, 1'b0, 1'b1, lo));
            step(4);
        end
        for (int k = 0; k < 2; k++)
        begin
            keep_wr = 1'b1;
            keep_val = k[0];
            warm_wr = 1'b1;
            warm_val = k[0];
            step(1);
            keep_wr = 1'b0;
            warm_wr = 1'b0;
            check({6'h0, stop_pin_drive_keep, warm_sel}, {6'h0, k[0], k[0]});
            halt(standby_pkg::HALT_SEL_STOP);
            step(4);
            check({1'b0, osc_enable, osc_out, pins_float, pins_hold, gated_inputs_en, periph_run,
                sys_clk_gate_en}, {3'h1, ~k[0], k[0], 3'h0});
            mreq = 1'b1;
            mlvl = 3'h6;
            no_wake(6);
            check(seen, 8'h0);
            mreq = 1'b0;
            warm = k ? 32 : 16;
            req_nmi = 1'b1;
            step(1);
            req_nmi = 1'b0;
            wait_wake(200);
            verdict(model(standby_pkg::HALT_SEL_STOP, mask, 1'b0, 3'h0, 1'b1, 1'b0, 3'h0));
            check({7'h0, cnt >= warm && cnt <= warm + 12}, 8'h1);
            check(8'(gate_hi), 8'h0);
            step(4);
        end
        halt(standby_pkg::HALT_SEL_RUN);
        req_nmi = 1'b1;
        step(1);
        req_nmi = 1'b0;
        wait_wake(6);
        verdict(model(standby_pkg::HALT_SEL_RUN, mask, 1'b0, 3'h0, 1'b1, 1'b0, 3'h0));
        step(4);
        // The source withdraws during entry, so only the held request can wake the block.
        req_nmi = 1'b1;
        halt(standby_pkg::HALT_SEL_IDLE);
        req_nmi = 1'b0;
        req_drop = 1'b1;
        step(1);
        req_drop = 1'b0;
        wait_wake(12);
        verdict(model(standby_pkg::HALT_SEL_IDLE, mask, 1'b0, 3'h0, 1'b1, 1'b0, 3'h0));
        check({7'h0, cnt <= standby_pkg::ENTRY_CYCLES + 1}, 8'h1);
        step(4);
        halt(standby_pkg::HALT_SEL_STOP);
        step(4);
        reset_n = 1'b0;
        step(standby_pkg::RESET_HOLD_CYCLES);
        check({4'h0, cpu_halted, osc_out, stop_pin_drive_keep, warm_sel}, 8'h0);
        reset_n = 1'b1;
        step(16370);
        check({7'h0, doubler_ready}, 8'h0);
        step(30);
        check({7'h0, doubler_ready}, 8'h1);
        final_report();
    end

    initial
    begin
        #(50 * 40000);
        n_mismatch++;
        final_report();
    end
endmodule : standby_halt_controller_test

// ==== bench/wake_requester.sv ====
`timescale 1ns/1ps
module wake_requester
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic req_nmi,
    input wire logic req_ext_irq_zero,
    input wire logic req_drop,
    input wire logic wake_release,
    output logic nmi_pin,
    output logic ext_irq_zero
);
    logic nmi_ff;
    logic ext_irq_zero_ff;
    // A level source must stay up until the halt is released, or the wake could be lost.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nmi_ff <= 1'b0;
            ext_irq_zero_ff <= 1'b0;
        end
        else if (wake_release || req_drop)
        begin
            nmi_ff <= 1'b0;
            ext_irq_zero_ff <= 1'b0;
        end
        else
        begin
            nmi_ff <= nmi_ff | req_nmi;
            ext_irq_zero_ff <= ext_irq_zero_ff | req_ext_irq_zero;
        end
    end
    assign nmi_pin = nmi_ff;
    assign ext_irq_zero = ext_irq_zero_ff;
endmodule : wake_requester

// ==== src/standby_halt_controller.sv ====
// What this block does
// - Halt instruction enters RUN, IDLE or STOP per halt_mode_select 00, 10, 01.
// - RUN keeps system clock going; CPU does dummy cycles until released.
// - Halted in RUN, pending requests are sampled every clock cycle.
// - IDLE stops system clock, oscillator runs; restart is clock synchronous.
// - IDLE wakes only on non-maskable input or external interrupt zero.
// - Peripherals run in RUN, halt in IDLE and STOP.
// - STOP stops everything and floats most pins, isolating them.
// - Keep bit holds pre-halt pin states in STOP; reset clears it.
// - STOP disables gated inputs, keeps wake inputs, drives osc_out high.
// - STOP wake restarts oscillator, clock enabled after warm-up count.
// - Warm-up select 0 gives 2^15 cycles, 1 gives 2^17; reset clears.
// - Clock doubler setup is fixed at 2^14 external clock cycles.
// - STOP ends only on non-maskable, external interrupt zero, or reset.
// - Warm-up runs on stop release even with external oscillator.
// - Interrupt zero above mask, or maskable request above mask in RUN, releases halt and is serviced.
// - Maskable request not above mask does not release halt.
// - Non-maskable request releases and is serviced regardless of mask.
// - Masked interrupt zero releases without service; its flag stays set.
// - Wake requests during 3-cycle entry are held pending, then release the halt.
// - Reset releases any halt; RAM kept, other settings initialised.
`timescale 1ns/1ps
module standby_halt_controller
#(
    parameter int WARM_SHORT = standby_pkg::WARM_SHORT_CYCLES,
    parameter int WARM_LONG = standby_pkg::WARM_LONG_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic halt_exec,
    input wire logic [1:0] halt_mode_select,
    input wire logic stop_pin_drive_keep_wr,
    input wire logic stop_pin_drive_keep_val,
    input wire logic warm_sel_wr,
    input wire logic warm_sel_val,
    input wire logic [2:0] interrupt_mask_level,
    input wire logic maskable_req,
    input wire logic [2:0] maskable_level,
    input wire logic nmi_pin,
    input wire logic ext_irq_zero,
    input wire logic [2:0] ext_irq_zero_level,
    output logic cpu_halted,
    output logic dummy_cycle,
    output logic sys_clk_gate_en,
    output logic periph_run,
    output logic osc_enable,
    output logic osc_out,
    output logic pins_float,
    output logic pins_hold,
    output logic gated_inputs_en,
    output logic wake_release,
    output logic wake_service,
    output logic [2:0] service_level,
    output logic irq0_flag_keep,
    output logic stop_pin_drive_keep,
    output logic warm_sel,
    output logic doubler_ready
);
    typedef enum logic [2:0] {ST_ACTIVE, ST_ENTRY, ST_RUN_HALT, ST_IDLE_HALT, ST_STOP_HALT, ST_WARM} state_e;

    state_e state_ff, nxt_state;
    logic [1:0] mode_ff, nxt_mode;
    logic [1:0] entry_cnt_ff, nxt_entry_cnt;
    logic pend_nmi_ff, nxt_pend_nmi;
    logic pend_ext_irq_zero_ff, nxt_pend_ext_irq_zero;
    logic keep_ff, nxt_keep;
    logic warm_ff, nxt_warm;
    logic warm_start;
    logic warm_done;
    logic [14:0] dbl_cnt_ff, nxt_dbl_cnt;
    logic dbl_ready_ff, nxt_dbl_ready;
    logic nmi_s1_ff, nmi_s2_ff, ext_irq_zero_s1_ff, ext_irq_zero_s2_ff;
    logic cpu_halted_ff, dummy_ff, clk_gate_ff, periph_ff, osc_en_ff, osc_out_ff;
    logic float_ff, hold_ff, gin_ff, rel_ff, svc_ff, keep0_ff;
    logic [2:0] svc_lvl_ff;
    logic nxt_rel, nxt_svc, nxt_keep0;
    logic [2:0] nxt_svc_lvl;
    logic nmi_now, ext_irq_zero_now, ext_irq_zero_above, mask_above;

    // Wake pins come from outside the clock domain.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            nmi_s1_ff <= 1'b0;
            nmi_s2_ff <= 1'b0;
            ext_irq_zero_s1_ff <= 1'b0;
            ext_irq_zero_s2_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            nmi_s1_ff <= nmi_pin;
            nmi_s2_ff <= nmi_s1_ff;
            ext_irq_zero_s1_ff <= ext_irq_zero;
            ext_irq_zero_s2_ff <= ext_irq_zero_s1_ff;
        end
    end

    assign nmi_now = nmi_s2_ff | pend_nmi_ff;
    assign ext_irq_zero_now = ext_irq_zero_s2_ff | pend_ext_irq_zero_ff;
    assign ext_irq_zero_above = ext_irq_zero_level > interrupt_mask_level;
    assign mask_above = maskable_req && (maskable_level > interrupt_mask_level);

    warmup_counter #(
        .SHORT_COUNT(WARM_SHORT),
        .LONG_COUNT(WARM_LONG)
    ) u_warm (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .start(warm_start),
        .long_sel(warm_ff),
        .done(warm_done)
    );

    always_comb
    begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_entry_cnt = entry_cnt_ff;
        nxt_pend_nmi = pend_nmi_ff;
        nxt_pend_ext_irq_zero = pend_ext_irq_zero_ff;
        nxt_keep = stop_pin_drive_keep_wr ? stop_pin_drive_keep_val : keep_ff;
        nxt_warm = warm_sel_wr ? warm_sel_val : warm_ff;
        nxt_rel = 1'b0;
        nxt_svc = 1'b0;
        nxt_svc_lvl = svc_lvl_ff;
        nxt_keep0 = 1'b0;
        warm_start = 1'b0;
        case (state_ff)
            ST_ACTIVE:
            begin
                if (halt_exec)
                begin
                    nxt_mode = halt_mode_select;
                    nxt_entry_cnt = '0;
                    if (halt_mode_select == standby_pkg::HALT_SEL_RUN)
                        nxt_state = ST_RUN_HALT;
                    else
                        nxt_state = ST_ENTRY;
                end
            end
            ST_ENTRY:
            begin
                // Wake edges in the entry window are held, not acted on.
                if (nmi_s2_ff)
                    nxt_pend_nmi = 1'b1;
                if (ext_irq_zero_s2_ff)
                    nxt_pend_ext_irq_zero = 1'b1;
                nxt_entry_cnt = entry_cnt_ff + 2'h1;
                if (entry_cnt_ff == standby_pkg::ENTRY_LAST)
                begin
                    if (mode_ff == standby_pkg::HALT_SEL_STOP)
                        nxt_state = ST_STOP_HALT;
                    else
                        nxt_state = ST_IDLE_HALT;
                end
            end
            ST_RUN_HALT:
            begin
                // Every cycle samples all sources; only the maskable request is compared with the mask.
                if (nmi_now || mask_above || ext_irq_zero_now)
                    nxt_state = ST_ACTIVE;
            end
            ST_IDLE_HALT:
            begin
                if (nmi_now || ext_irq_zero_now)
                    nxt_state = ST_ACTIVE;
            end
            ST_STOP_HALT:
            begin
                if (nmi_now || ext_irq_zero_now)
                begin
                    warm_start = 1'b1;
                    nxt_state = ST_WARM;
                end
            end
            ST_WARM:
            begin
                if (warm_done)
                    nxt_state = ST_ACTIVE;
            end
            default:
                nxt_state = ST_ACTIVE;
        endcase
        if ((state_ff == ST_RUN_HALT || state_ff == ST_IDLE_HALT || state_ff == ST_WARM) &&
            nxt_state == ST_ACTIVE)
        begin
            nxt_rel = 1'b1;
            nxt_pend_nmi = 1'b0;
            nxt_pend_ext_irq_zero = 1'b0;
            if (nmi_now)
            begin
                nxt_svc = 1'b1;
                nxt_svc_lvl = standby_pkg::NMI_LEVEL;
            end
            else if (mask_above && !(ext_irq_zero_now && ext_irq_zero_above && ext_irq_zero_level >= maskable_level))
            begin
                nxt_svc = 1'b1;
                nxt_svc_lvl = maskable_level;
            end
            else if (ext_irq_zero_now && ext_irq_zero_above)
            begin
                nxt_svc = 1'b1;
                nxt_svc_lvl = ext_irq_zero_level;
            end
            else
                nxt_keep0 = 1'b1;
        end
    end

    // Doubler setup time after reset release.
    always_comb
    begin
        nxt_dbl_cnt = dbl_cnt_ff;
        nxt_dbl_ready = dbl_ready_ff;
        if (!dbl_ready_ff)
        begin
            if (dbl_cnt_ff == 15'(standby_pkg::DOUBLER_CYCLES - 1))
                nxt_dbl_ready = 1'b1;
            else
                nxt_dbl_cnt = dbl_cnt_ff + 15'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // Reset ends any halt and reinitialises settings.
            state_ff <= ST_ACTIVE;
            mode_ff <= 2'h0;
            entry_cnt_ff <= 2'h0;
            pend_nmi_ff <= 1'b0;
            pend_ext_irq_zero_ff <= 1'b0;
            keep_ff <= standby_pkg::STOP_KEEP_RESET;
            warm_ff <= standby_pkg::WARM_SEL_RESET;
            rel_ff <= 1'b0;
            svc_ff <= 1'b0;
            svc_lvl_ff <= 3'h0;
            keep0_ff <= 1'b0;
            dbl_cnt_ff <= 15'h0;
            dbl_ready_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            entry_cnt_ff <= nxt_entry_cnt;
            pend_nmi_ff <= nxt_pend_nmi;
            pend_ext_irq_zero_ff <= nxt_pend_ext_irq_zero;
            keep_ff <= nxt_keep;
            warm_ff <= nxt_warm;
            rel_ff <= nxt_rel;
            svc_ff <= nxt_svc;
            svc_lvl_ff <= nxt_svc_lvl;
            keep0_ff <= nxt_keep0;
            dbl_cnt_ff <= nxt_dbl_cnt;
            dbl_ready_ff <= nxt_dbl_ready;
        end
    end

    // Output flops decoded from the next state so they align with it.
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cpu_halted_ff <= 1'b0;
            dummy_ff <= 1'b0;
            clk_gate_ff <= 1'b1;
            periph_ff <= 1'b1;
            osc_en_ff <= 1'b1;
            osc_out_ff <= 1'b0;
            float_ff <= 1'b0;
            hold_ff <= 1'b0;
            gin_ff <= 1'b1;
        end
        else if (clk_en)
        begin
            cpu_halted_ff <= nxt_state != ST_ACTIVE;
            dummy_ff <= nxt_state == ST_RUN_HALT;
            clk_gate_ff <= nxt_state == ST_ACTIVE || nxt_state == ST_RUN_HALT;
            periph_ff <= nxt_state == ST_ACTIVE || nxt_state == ST_RUN_HALT;
            osc_en_ff <= nxt_state != ST_STOP_HALT;
            osc_out_ff <= nxt_state == ST_STOP_HALT;
            float_ff <= nxt_state == ST_STOP_HALT && !nxt_keep;
            hold_ff <= nxt_state == ST_STOP_HALT && nxt_keep;
            gin_ff <= nxt_state != ST_STOP_HALT;
        end
    end

    assign cpu_halted = cpu_halted_ff;
    assign dummy_cycle = dummy_ff;
    assign sys_clk_gate_en = clk_gate_ff;
    assign periph_run = periph_ff;
    assign osc_enable = osc_en_ff;
    assign osc_out = osc_out_ff;
    assign pins_float = float_ff;
    assign pins_hold = hold_ff;
    assign gated_inputs_en = gin_ff;
    assign wake_release = rel_ff;
    assign wake_service = svc_ff;
    assign service_level = svc_lvl_ff;
    assign irq0_flag_keep = keep0_ff;
    assign stop_pin_drive_keep = keep_ff;
    assign warm_sel = warm_ff;
    assign doubler_ready = dbl_ready_ff;

    property p_idle_clock_off;
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && state_ff == ST_IDLE_HALT |-> !sys_clk_gate_en;
    endproperty
    a_idle_clock_off: assert property (p_idle_clock_off) else $error("Clock running in idle.");

    property p_idle_ignores_maskable;
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && state_ff == ST_IDLE_HALT && !nmi_now && !ext_irq_zero_now |=> state_ff == ST_IDLE_HALT;
    endproperty
    a_idle_ignores_maskable: assert property (p_idle_ignores_maskable) else $error("Idle left wrongly.");

    property p_stop_osc_high;
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && state_ff == ST_STOP_HALT |-> osc_out && !osc_enable && !gated_inputs_en;
    endproperty
    a_stop_osc_high: assert property (p_stop_osc_high) else $error("Stop pin states wrong.");

    property p_stop_wake_sources;
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && state_ff == ST_STOP_HALT && !nmi_now && !ext_irq_zero_now |=> state_ff == ST_STOP_HALT;
    endproperty
    a_stop_wake_sources: assert property (p_stop_wake_sources) else $error("Stop left wrongly.");

    property p_warm_clock_gated;
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && state_ff == ST_WARM && !warm_done |=> !sys_clk_gate_en;
    endproperty
    a_warm_clock_gated: assert property (p_warm_clock_gated) else $error("Clock before warm-up.");

    property p_run_clock_on;
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && state_ff == ST_RUN_HALT |=> sys_clk_gate_en && periph_run;
    endproperty
    a_run_clock_on: assert property (p_run_clock_on) else $error("Run halt stopped clock.");

    property p_nmi_serviced;
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && state_ff == ST_RUN_HALT && nmi_now |=> wake_service && service_level == 3'h7;
    endproperty
    a_nmi_serviced: assert property (p_nmi_serviced) else $error("NMI not serviced.");

    property p_entry_three;
        @(posedge sys_clk) disable iff (!reset_n)
        clk_en && state_ff == ST_ACTIVE && halt_exec && halt_mode_select != 2'h0 ##1 clk_en[*3]
            |=> state_ff == ST_IDLE_HALT || state_ff == ST_STOP_HALT;
    endproperty
    a_entry_three: assert property (p_entry_three) else $error("Entry not three cycles.");

    property p_keep_float;
        @(posedge sys_clk) disable iff (!reset_n)
        pins_float |-> !stop_pin_drive_keep && !pins_hold;
    endproperty
    a_keep_float: assert property (p_keep_float) else $error("Float with keep set.");
endmodule : standby_halt_controller

// ==== src/standby_pkg.sv ====
package standby_pkg;
    localparam logic [1:0] HALT_SEL_RUN = 2'h0;
    localparam logic [1:0] HALT_SEL_IDLE = 2'h2;
    localparam logic [1:0] HALT_SEL_STOP = 2'h1;
    localparam int LEVEL_W = 3;
    localparam logic [2:0] NMI_LEVEL = 3'h7;
    localparam int ENTRY_CYCLES = 3;
    localparam logic [1:0] ENTRY_LAST = 2'h2;
    localparam int WARM_W = 18;
    localparam int WARM_SHORT_CYCLES = 32768;
    localparam int WARM_LONG_CYCLES = 131072;
    localparam int DOUBLER_CYCLES = 16384;
    localparam real RESET_HOLD_US = 2.0;
    localparam real CLK_MHZ = 20.0;
    localparam int RESET_HOLD_CYCLES = int'(RESET_HOLD_US * CLK_MHZ);
    localparam logic STOP_KEEP_RESET = 1'b0;
    localparam logic WARM_SEL_RESET = 1'b0;
endpackage : standby_pkg

// ==== src/warmup_counter.sv ====
`timescale 1ns/1ps
module warmup_counter
#(
    parameter int SHORT_COUNT = standby_pkg::WARM_SHORT_CYCLES,
    parameter int LONG_COUNT = standby_pkg::WARM_LONG_CYCLES
)
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic start,
    input wire logic long_sel,
    output logic done
);
    logic [standby_pkg::WARM_W-1:0] count_ff;
    logic [standby_pkg::WARM_W-1:0] nxt_count;
    logic run_ff;
    logic nxt_run;
    logic done_ff;
    logic nxt_done;
    logic [standby_pkg::WARM_W-1:0] limit;

    assign limit = long_sel ? standby_pkg::WARM_W'(LONG_COUNT - 1) : standby_pkg::WARM_W'(SHORT_COUNT - 1);

    // The count restarts from zero on every start and pulses done at the terminal count.
    always_comb
    begin
        nxt_count = count_ff;
        nxt_run = run_ff;
        nxt_done = 1'b0;
        if (start)
        begin
            nxt_count = '0;
            nxt_run = 1'b1;
        end
        else if (run_ff)
        begin
            if (count_ff == limit)
            begin
                nxt_run = 1'b0;
                nxt_done = 1'b1;
            end
            else
            begin
                nxt_count = count_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count_ff <= '0;
            run_ff <= 1'b0;
            done_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            count_ff <= nxt_count;
            run_ff <= nxt_run;
            done_ff <= nxt_done;
        end
    end

    assign done = done_ff;
endmodule : warmup_counter
